// [rtl/pmcc_params.svh]
// Purpose: Constants of the power mode and clock control block.
// Assumes: Included by its bare name from each design file that needs it.
// Notes:   Byte address is four times the index.
`ifndef PMCC_PARAMS_SVH
`define PMCC_PARAMS_SVH

// ==========================================================
// Register indices in expanded bank F.
`define PMCC_IDX_PORT_CONFIG 4'h0
`define PMCC_IDX_STOP_RECOVERY 4'hB
`define PMCC_IDX_STATUS 4'hC

// ==========================================================
// Field positions.
`define PMCC_PORT_CONFIG_REG_COMP_OUT 0
`define PMCC_PORT_CONFIG_REG_P0_PULLUP 2
`define PMCC_PORT_CONFIG_REG_P0_STD 3
`define PMCC_PORT_CONFIG_REG_P2_STD 5
`define PMCC_PORT_CONFIG_REG_P3_STD 6
`define PMCC_PORT_CONFIG_REG_OSC_STD 7
`define PMCC_SMR_DIV16 0
`define PMCC_SMR_DIV2_BYPASS 1
`define PMCC_SMR_WARM 7

// ==========================================================
// Reset values and write masks.
`define PMCC_PORT_CONFIG_REG_RESET 8'hEC
`define PMCC_PORT_CONFIG_REG_WMASK 8'hED
`define PMCC_SMR_RESET 8'h20
`define PMCC_SMR_WMASK 8'h7F

// ==========================================================
// Wake source codes.
`define PMCC_SRC_POR_ONLY 3'h0
`define PMCC_SRC_WAKE0 3'h1
`define PMCC_SRC_WAKE1 3'h4
`define PMCC_SRC_WAKE2 3'h5
`define PMCC_SRC_WAKE3 3'h3
`define PMCC_SRC_NOR_LOW 3'h2
`define PMCC_SRC_NOR_ALL 3'h6

// ==========================================================
// Opcodes and timing.
`define PMCC_OP_NOP 8'hFF
`define PMCC_OP_STOP 8'h6F
`define PMCC_OP_HALT 8'h7F
`define PMCC_RESTART_ADDR 16'h000C
`define PMCC_POR_TIME_NS 5000000
`define PMCC_RC_PERIOD_NS 1000
`define PMCC_POR_RC_TICKS (`PMCC_POR_TIME_NS / `PMCC_RC_PERIOD_NS)

`endif

// [rtl/pmcc_pkg.sv]
// Purpose: Types shared by the power mode and clock control block.
// Assumes: Constants live in pmcc_params.svh.
// Notes:   Struct layouts follow the register bit order, MSB first.
package pmcc_pkg;

  // ==========================================================
  // Operating states.
  typedef enum logic [1:0] {
    PMCC_DELAY,
    PMCC_RUN,
    PMCC_HALT,
    PMCC_STOP
  } pmcc_state_e;

  // ==========================================================
  // Port configuration register layout.
  typedef struct packed {
    logic osc_std;
    logic p3_std;
    logic p2_std;
    logic rsv4;
    logic p0_std;
    logic p0_pullup;
    logic rsv1;
    logic comp_out;
  } pmcc_port_config_reg_s;

  // Stop recovery register layout.
  typedef struct packed {
    logic warm;
    logic level;
    logic delay;
    logic [2:0] src;
    logic div2_bypass;
    logic div16;
  } pmcc_smr_s;

endpackage

// [rtl/pmcc_oneshot.sv]
// Purpose: One-shot delay timer advanced by ticks of a slow oscillator.
// Assumes: tick_in is a one-cycle pulse.
// Notes:   A new start restarts the count from zero.
`timescale 1ns/100ps
module pmcc_oneshot #(
  parameter int COUNT = 5000
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Control.
  input wire logic start_in,
  input wire logic tick_in,
  // Status.
  output logic busy_out,
  output logic done_out
);
  localparam int CW = $clog2(COUNT + 1);

  generate
    if (COUNT < 1) begin : g_chk
      $error("pmcc_oneshot: COUNT must be at least one");
    end
  endgenerate

  logic [CW-1:0] count;

  // ==========================================================
  // Count ticks while busy; done pulses once at the last tick.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count <= '0;
        busy_out <= 1'b1;
      end else if (busy_out && tick_in) begin
        if (count == CW'(COUNT - 1)) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule

// [rtl/pmcc_clk_div.sv]
// Purpose: System and timer clock enable generator.
// Assumes: The input clock stands for the crystal clock.
// Notes:   Divides by two unless bypassed, and by sixteen more when asked.
`timescale 1ns/100ps
module pmcc_clk_div (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Divider control.
  input wire logic div2_bypass_in,
  input wire logic div16_in,
  // One-cycle enable at the divided rate.
  output logic tick_out
);
  logic [4:0] count;
  logic [4:0] last;

  // Terminal count for the chosen ratio of 1, 2, 16 or 32.
  always_comb begin
    last = {div16_in & ~div2_bypass_in, div16_in, div16_in, div16_in, div16_in | ~div2_bypass_in};
  end

  // ==========================================================
  // A ratio change takes effect at once; a count already past the new end wraps, so no tick is lost.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= 5'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (count >= last);
      count <= (count >= last) ? 5'h00 : count + 5'h01;
    end
  end
endmodule

// [rtl/pmcc_top.sv]
// Purpose: Clock, low-power and stop recovery control of an 8-bit controller.
// Assumes: Inputs synchronous to the always-on clk_in.
// Notes:   Avalon-MM slave, one-cycle answer.
`timescale 1ns/100ps
`include "pmcc_params.svh"

// Summary of operation
// - One-shot delay starts on power-OK, delayed stop recovery, or watchdog time-out.
// - Delay counts the dedicated RC oscillator; execution waits until it expires.
// - Stop recovery bit 5 chooses whether the delay is skipped after STOP.
// - HALT gates the CPU clock; oscillator, timers and external interrupts keep running.
// - Any interrupt, external or internal, ends HALT.
// - Opcode 6F enters STOP, opcode 7F enters HALT.
// - STOP halts the internal clock and the crystal oscillator.
// - STOP ends only by a reset source; execution restarts at 000C.
// - Port config D0 routes both comparator outputs to port 3 pins 4 and 7.
// - Port config D2 selects open-drain or pulled-up port 0, default pulled up.
// - Port config D3, D5, D6 select low-EMI or standard drive, default standard.
// - Port config D7 selects oscillator drive without changing the clock ratio.
// - Port configuration register sits at bank F location 00.
// - Stop recovery bits are write-only except bit 7, the warm-start flag.
// - Stop recovery bit 6 picks the wake level.
// - Stop recovery bits 2 to 4 pick the wake source.
// - Stop recovery register sits at bank F address 0BH.
// - Stop recovery D0 adds divide-by-16 to system and timer clocks; cleared on recovery.
// - Stop recovery D1 low halves the clocks, high passes them; default low.
// - Source codes map to power-on only, wake pins, or NOR of port 2.
// - Wake level bit high means high level wakes; default low after power-on.
// - Stop recovery keeps the configuration registers instead of resetting them.
module pmcc_top #(
  parameter int POR_TICKS = `PMCC_POR_RC_TICKS
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Reset sources and slow oscillator.
  input wire logic power_ok_in,
  input wire logic watchdog_timeout_in,
  input wire logic rc_tick_in,
  // CPU core side.
  input wire logic opcode_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic irq_pending_in,
  output logic cpu_clk_en_out,
  output logic timer_clk_en_out,
  output logic cpu_run_out,
  output logic restart_out,
  output logic [15:0] restart_addr_out,
  // Wake-up pins.
  input wire logic [3:0] wake_pin_in,
  input wire logic [7:0] port2_in,
  // Comparator routing on port 3.
  input wire logic [1:0] comparator_in,
  input wire logic [1:0] port3_data_in,
  output logic comparator_out_a_pin_out,
  output logic comparator_out_b_pin_out,
  // Pad and oscillator control.
  output logic osc_enable_out,
  output logic osc_std_drive_out,
  output logic port0_pullup_out,
  output logic port0_std_drive_out,
  output logic port2_std_drive_out,
  output logic port3_std_drive_out
);

  generate
    if (POR_TICKS < 1) begin : g_chk
      $error("pmcc_top: POR_TICKS must be at least one");
    end
  endgenerate

  // ==========================================================
  // Declarations.
  pmcc_pkg::pmcc_state_e state;
  pmcc_pkg::pmcc_port_config_reg_s port_config_reg;
  pmcc_pkg::pmcc_smr_s stop_recovery_reg;
  logic power_ok_prev;
  logic por_event;
  logic wdt_event;
  logic delay_start;
  logic delay_busy;
  logic delay_done;
  logic wake_raw;
  logic wake_level;
  logic wake_hit;
  logic stop_recover;
  logic sys_tick;
  logic last_was_nop;
  logic [3:0] reg_index;
  logic bus_req;
  logic bus_take;
  logic wr_en;
  logic [7:0] rd_byte;

  // ==========================================================
  // Reset source detection.
  // Only a power-OK rise counts as power-on.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      power_ok_prev <= 1'b0;
    end else begin
      power_ok_prev <= power_ok_in;
    end
  end

  assign por_event = power_ok_in & ~power_ok_prev;
  assign wdt_event = watchdog_timeout_in & power_ok_in;

  // ==========================================================
  // Wake source selection, a pure level path needing no crystal clock.
  always_comb begin
    unique case (stop_recovery_reg.src)
      `PMCC_SRC_WAKE0: wake_raw = wake_pin_in[0];
      `PMCC_SRC_WAKE1: wake_raw = wake_pin_in[1];
      `PMCC_SRC_WAKE2: wake_raw = wake_pin_in[2];
      `PMCC_SRC_WAKE3: wake_raw = wake_pin_in[3];
      `PMCC_SRC_NOR_LOW: wake_raw = ~|port2_in[3:0];
      `PMCC_SRC_NOR_ALL: wake_raw = ~|port2_in;
      default: wake_raw = 1'b0;
    endcase
  end

  // Power-on only and the unused code never wake the device.
  assign wake_level = (stop_recovery_reg.src == `PMCC_SRC_POR_ONLY) || (stop_recovery_reg.src == 3'h7)
                      ? 1'b0 : 1'b1;
  // The selected level, high or low, is the wake condition.
  assign wake_hit = wake_level & (wake_raw == stop_recovery_reg.level);
  // Sampled on the always-on clock, not on the stopped crystal clock.
  assign stop_recover = (state == pmcc_pkg::PMCC_STOP) & wake_hit & ~wdt_event & ~por_event;

  // ==========================================================
  // Power-on delay timer, clocked by the dedicated RC oscillator ticks.
  // A fast wake relies on the source standing long enough.
  assign delay_start = por_event | wdt_event | (stop_recover & stop_recovery_reg.delay);

  pmcc_oneshot #(
    .COUNT(POR_TICKS)
  ) u_delay (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .start_in(delay_start),
    .tick_in(rc_tick_in),
    .busy_out(delay_busy),
    .done_out(delay_done)
  );

  // ==========================================================
  // System and timer clock divider.
  pmcc_clk_div u_div (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .div2_bypass_in(stop_recovery_reg.div2_bypass),
    .div16_in(stop_recovery_reg.div16),
    .tick_out(sys_tick)
  );

  // ==========================================================
  // Flush history: a no-op should precede sleep.
  // An unflushed sleep is not refused; the sleep opcode itself clears last_was_nop.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      last_was_nop <= 1'b0;
    end else if (opcode_valid_in) begin
      last_was_nop <= (opcode_in == `PMCC_OP_NOP);
    end
  end

  // ==========================================================
  // Operating state.
  // Reset sources win; a power fail parks the block in DELAY.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= pmcc_pkg::PMCC_DELAY;
    end else if (!power_ok_in || delay_start) begin
      state <= pmcc_pkg::PMCC_DELAY;
    end else begin
      unique case (state)
        pmcc_pkg::PMCC_DELAY: begin
          if (delay_done) begin
            state <= pmcc_pkg::PMCC_RUN;
          end
        end
        pmcc_pkg::PMCC_RUN: begin
          if (opcode_valid_in && opcode_in == `PMCC_OP_STOP) begin
            state <= pmcc_pkg::PMCC_STOP;
          end else if (opcode_valid_in && opcode_in == `PMCC_OP_HALT) begin
            state <= pmcc_pkg::PMCC_HALT;
          end
        end
        pmcc_pkg::PMCC_HALT: begin
          if (irq_pending_in) begin
            state <= pmcc_pkg::PMCC_RUN;
          end
        end
        pmcc_pkg::PMCC_STOP: begin
          if (stop_recover) begin
            state <= pmcc_pkg::PMCC_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Restart pulse and start address after any reset path.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      restart_out <= 1'b0;
      restart_addr_out <= `PMCC_RESTART_ADDR;
    end else begin
      restart_out <= power_ok_in & ~delay_start & ((state == pmcc_pkg::PMCC_DELAY & delay_done) | stop_recover);
      restart_addr_out <= `PMCC_RESTART_ADDR;
    end
  end

  // ==========================================================
  // Clock gating and oscillator control.
  // HALT keeps the timer clock and the crystal; STOP kills both.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cpu_clk_en_out <= 1'b0;
      timer_clk_en_out <= 1'b0;
      cpu_run_out <= 1'b0;
      osc_enable_out <= 1'b1;
    end else begin
      cpu_clk_en_out <= sys_tick & (state == pmcc_pkg::PMCC_RUN);
      timer_clk_en_out <= sys_tick & ((state == pmcc_pkg::PMCC_RUN) | (state == pmcc_pkg::PMCC_HALT));
      cpu_run_out <= (state == pmcc_pkg::PMCC_RUN);
      osc_enable_out <= (state != pmcc_pkg::PMCC_STOP);
    end
  end

  // ==========================================================
  // Avalon-MM handshake.
  // Waitrequest drops one cycle after a request is seen;
  // a write lands at the edge where it is seen low.
  assign bus_req = avs_read_in | avs_write_in;
  assign bus_take = bus_req & avs_waitrequest_out;
  assign reg_index = avs_address_in[5:2];
  assign wr_en = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= ~bus_take;
    end
  end

  // Read multiplexer; write-only and reserved bits read as zero.
  always_comb begin
    unique case (reg_index)
      `PMCC_IDX_PORT_CONFIG: rd_byte = port_config_reg & `PMCC_PORT_CONFIG_REG_WMASK;
      `PMCC_IDX_STOP_RECOVERY: rd_byte = {stop_recovery_reg.warm, 7'h00};
      `PMCC_IDX_STATUS: rd_byte = {3'h0, last_was_nop, delay_busy, osc_enable_out, state};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (bus_take && avs_read_in) begin
      avs_readdata_out <= {24'h000000, rd_byte};
    end
  end

  // ==========================================================
  // Port configuration register.
  // Power-on and watchdog reload it; stop recovery keeps it.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port_config_reg <= `PMCC_PORT_CONFIG_REG_RESET;
    end else if (por_event || wdt_event || !power_ok_in) begin
      port_config_reg <= `PMCC_PORT_CONFIG_REG_RESET;
    end else if (wr_en && reg_index == `PMCC_IDX_PORT_CONFIG) begin
      port_config_reg <= avs_writedata_in[7:0] & `PMCC_PORT_CONFIG_REG_WMASK;
    end
  end

  // ==========================================================
  // Stop recovery register.
  // Stop recovery clears divide-by-16 and sets the warm flag;
  // only power-on or power fail clears the flag, and a power fail clear wins over a set in the same cycle.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stop_recovery_reg <= `PMCC_SMR_RESET;
    end else if (!power_ok_in || por_event) begin
      stop_recovery_reg <= `PMCC_SMR_RESET;
    end else if (wdt_event) begin
      stop_recovery_reg <= {stop_recovery_reg.warm, 7'h20};
    end else if (stop_recover) begin
      stop_recovery_reg.warm <= 1'b1;
      stop_recovery_reg.div16 <= 1'b0;
    end else if (wr_en && reg_index == `PMCC_IDX_STOP_RECOVERY) begin
      stop_recovery_reg <= {stop_recovery_reg.warm, avs_writedata_in[6:0]};
    end
  end

  // ==========================================================
  // Comparator routing and pad drive controls, all registered.
  // Oscillator drive never reaches the divider, so the ratio holds.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      comparator_out_a_pin_out <= 1'b0;
      comparator_out_b_pin_out <= 1'b0;
      osc_std_drive_out <= 1'b1;
      port0_pullup_out <= 1'b1;
      port0_std_drive_out <= 1'b1;
      port2_std_drive_out <= 1'b1;
      port3_std_drive_out <= 1'b1;
    end else begin
      comparator_out_a_pin_out <= port_config_reg.comp_out ? comparator_in[0] : port3_data_in[0];
      comparator_out_b_pin_out <= port_config_reg.comp_out ? comparator_in[1] : port3_data_in[1];
      osc_std_drive_out <= port_config_reg.osc_std;
      port0_pullup_out <= port_config_reg.p0_pullup;
      port0_std_drive_out <= port_config_reg.p0_std;
      port2_std_drive_out <= port_config_reg.p2_std;
      port3_std_drive_out <= port_config_reg.p3_std;
    end
  end

endmodule

// [tb/pmcc_properties.sv]
// Purpose: Port timing properties of the power mode clock control block.
// Assumes: One clock domain and an active-low asynchronous reset.
// Notes:   Latencies follow the bus answer and sleep entry.
`timescale 1ns/100ps
module pmcc_properties (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Watched ports.
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic power_ok_in,
  input wire logic opcode_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic cpu_clk_en_out,
  input wire logic cpu_run_out,
  input wire logic restart_out,
  input wire logic [15:0] restart_addr_out,
  input wire logic osc_enable_out
);
  // ==========================================================
  // Properties.
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic req;
  logic go_run;
  // Sleep opcodes count only in RUN on good power.
  assign req = avs_read_in || avs_write_in;
  assign go_run = opcode_valid_in && cpu_run_out && power_ok_in;
  a_bus_answer: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  a_answer_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("bus answer too long");
  a_bus_quiet: assert property (!req && avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("bus answer without request");
  a_halt_entry: assert property (go_run && opcode_in == 8'h7F |-> ##3 !cpu_run_out && osc_enable_out)
    else $error("halt entry wrong");
  a_stop_entry: assert property (go_run && opcode_in == 8'h6F |-> ##3 !cpu_run_out && !osc_enable_out)
    else $error("stop entry wrong");
  a_stop_quiet: assert property (!osc_enable_out |-> !cpu_clk_en_out && !cpu_run_out)
    else $error("clock runs in stop");
  a_restart_once: assert property (restart_out |=> !restart_out)
    else $error("restart pulse too long");
  a_restart_vector: assert property (restart_out |-> restart_addr_out == 16'h000C ##1 cpu_run_out)
    else $error("restart vector wrong");
  a_power_hold: assert property (!power_ok_in [*3] |-> !cpu_run_out && !restart_out)
    else $error("runs during power fail");
  // Main scenarios.
  c_restart: cover property (restart_out);
  c_stop: cover property (!osc_enable_out);
  c_halt: cover property ($fell(cpu_run_out) && osc_enable_out);
endmodule

// [tb/pmcc_core_model.sv]
// Purpose: Core, slow RC oscillator and sleep sequencer facing the block.
// Assumes: go_in is a one-cycle pulse.
// Notes:   Opcode lines toggle while not valid.
`timescale 1ns/100ps
module pmcc_core_model (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic resetn_in,
  // Sleep request.
  input wire logic go_in,
  input wire logic [7:0] op_in,
  // Core and oscillator side.
  output logic opcode_valid_out,
  output logic [7:0] opcode_out,
  output logic rc_tick_out
);
  logic [2:0] rc_cnt;
  logic pend;
  // ==========================================================
  // RC oscillator: a tick every fifth cycle.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rc_cnt <= 3'h0;
      rc_tick_out <= 1'b0;
    end else begin
      rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
      rc_tick_out <= (rc_cnt == 3'h4);
    end
  end
  // A flushing no-op goes out before the sleep opcode.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend <= 1'b0;
      opcode_valid_out <= 1'b0;
      opcode_out <= 8'h00;
    end else begin
      pend <= go_in;
      opcode_valid_out <= go_in || pend;
      opcode_out <= go_in ? 8'hFF : (pend ? op_in : ~opcode_out);
    end
  end
endmodule

// [tb/test_power_mode_clock_control.sv]
// Purpose: Self-checking bench of the power mode and clock control block.
// Assumes: Byte address is four times the register index.
// Notes:   Four power-on ticks keep delayed restarts short.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module test_power_mode_clock_control;
  int miscompares = 0, checks = 0, cycles = 0, i, p, k, j;
  logic clk_in = 1'b0, resetn_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0, go = 1'b0;
  logic power_ok_in = 1'b0, watchdog_timeout_in = 1'b0, irq_pending_in = 1'b0, opcode_valid_in, rc_tick_in;
  logic [5:0] avs_address_in = 6'h00;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic [1:0] comparator_in = 2'h0, port3_data_in = 2'h0;
  logic [3:0] wake_pin_in = 4'h0;
  logic [7:0] port2_in = 8'h00, op = 8'hFF, opcode_in, q, d, port_config_reg_exp;
  logic [4:0] dv;
  logic [2:0] src_tab [4] = '{3'h1, 3'h4, 3'h5, 3'h3};
  logic [7:0] smr_tab [4] = '{8'h22, 8'h21, 8'h23, 8'h20};
  logic [15:0] restart_addr_out;
  logic avs_waitrequest_out, cpu_clk_en_out, timer_clk_en_out, cpu_run_out, restart_out, osc_enable_out;
  logic comparator_out_a_pin_out, comparator_out_b_pin_out, osc_std_drive_out, port0_pullup_out;
  logic port0_std_drive_out, port2_std_drive_out, port3_std_drive_out;
  // ==========================================================
  // Design, partner model and clock.
  pmcc_top #(.POR_TICKS(4)) pmcc_top_inst (.clk_in, .resetn_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hF), .avs_readdata_out, .avs_waitrequest_out,
    .power_ok_in, .watchdog_timeout_in, .rc_tick_in, .opcode_valid_in, .opcode_in, .irq_pending_in,
    .cpu_clk_en_out, .timer_clk_en_out, .cpu_run_out, .restart_out, .restart_addr_out, .wake_pin_in,
    .port2_in, .comparator_in, .port3_data_in, .comparator_out_a_pin_out, .comparator_out_b_pin_out,
    .osc_enable_out, .osc_std_drive_out, .port0_pullup_out, .port0_std_drive_out, .port2_std_drive_out,
    .port3_std_drive_out);
  pmcc_core_model pmcc_core_model_inst (.clk_in, .resetn_in, .go_in(go), .op_in(op),
    .opcode_valid_out(opcode_valid_in), .opcode_out(opcode_in), .rc_tick_out(rc_tick_in));
  always #20 clk_in = ~clk_in;
  // A hang counts as a mismatch.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end
  // ==========================================================
  // Tasks and expectation helpers.
  task automatic complete_run();
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One bus cycle, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] wd);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, wd};
    avs_read_in <= !wr;
    avs_write_in <= wr;
    @(posedge clk_in iff avs_waitrequest_out === 1'b0);
    q = avs_readdata_out[7:0];
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic doze(input logic [7:0] o);
    op <= o;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
  task automatic wait_restart(input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (restart_out !== 1'b1 && n < 200);
    `CHK("restart time", 1'b1, n >= lo && n <= hi)
    `CHK("restart addr", 16'h000C, restart_addr_out)
    @(posedge clk_in);
  endtask
  // Gap between two later enable pulses.
  task automatic period();
    repeat (2) begin
      do @(negedge clk_in); while (cpu_clk_en_out !== 1'b1);
    end
    p = 0;
    do begin
      @(negedge clk_in);
      p++;
    end while (cpu_clk_en_out !== 1'b1 && p < 99);
    @(posedge clk_in);
  endtask
  function automatic int exp_period(input logic [7:0] s);
    return (s[1] ? 1 : 2) * (s[0] ? 16 : 1);
  endfunction
  // ==========================================================
  // Main sequence.
  initial begin
    void'($urandom(32'h3be1c308));
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    bus(1'b0, 6'h00, 8'h00);
    `CHK("port_config_reg reset", 8'hEC, q)
    bus(1'b0, 6'h2C, 8'h00);
    `CHK("smr reset", 8'h00, q)
    bus(1'b1, 6'h3C, 8'h5A);
    bus(1'b0, 6'h3C, 8'h00);
    `CHK("unmapped", 8'h00, q)
    power_ok_in <= 1'b1;
    wait_restart(12, 40);
    // Port config: corners, then random bytes.
    for (i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h00 : ((i == 1) ? 8'hFF : 8'($urandom));
      comparator_in <= 2'($urandom);
      port3_data_in <= 2'($urandom);
      bus(1'b1, 6'h00, d);
      bus(1'b0, 6'h00, 8'h00);
      port_config_reg_exp = d & 8'hED;
      dv = {osc_std_drive_out, port3_std_drive_out, port2_std_drive_out, port0_std_drive_out, port0_pullup_out};
      `CHK("port_config_reg", port_config_reg_exp, q)
      `CHK("drives", {d[7], d[6], d[5], d[3], d[2]}, dv)
      `CHK("comp", d[0] ? comparator_in : port3_data_in, {comparator_out_b_pin_out, comparator_out_a_pin_out})
    end
    // Clock ratios; ends at divide-by-two.
    for (i = 0; i < 4; i++) begin
      bus(1'b1, 6'h2C, smr_tab[i]);
      period();
      `CHK("period", exp_period(smr_tab[i]), p)
    end
    doze(8'h7F);
    `CHK("halt run", 1'b0, cpu_run_out)
    k = 0;
    j = 0;
    repeat (40) begin
      @(negedge clk_in);
      k += timer_clk_en_out;
      j += cpu_clk_en_out;
    end
    `CHK("halt timer", 20, k)
    `CHK("halt cpu", 0, j)
    irq_pending_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    `CHK("halt wake", 1'b1, cpu_run_out)
    irq_pending_in <= 1'b0;
    // Fast wake per pin; the other pins stand high and must not wake.
    for (i = 0; i < 4; i++) begin
      wake_pin_in <= 4'hF & ~(4'h1 << i);
      bus(1'b1, 6'h2C, 8'h41 | {3'h0, src_tab[i], 2'h0});
      doze(8'h6F);
      repeat (10) @(posedge clk_in);
      `CHK("stop osc", 1'b0, osc_enable_out)
      wake_pin_in <= 4'hF;
      wait_restart(1, 6);
      bus(1'b0, 6'h2C, 8'h00);
      `CHK("warm", 8'h80, q)
      bus(1'b0, 6'h00, 8'h00);
      `CHK("port_config_reg kept", port_config_reg_exp, q)
      wake_pin_in <= 4'h0;
      period();
      `CHK("div16 off", 2, p)
    end
    // Delayed wake on port 2 NOR, half then all bits.
    for (i = 0; i < 2; i++) begin
      port2_in <= (i == 0) ? 8'hF0 : 8'h00;
      bus(1'b1, 6'h2C, (i == 0) ? 8'h28 : 8'h38);
      doze(8'h6F);
      repeat (10) @(posedge clk_in);
      `CHK("nor idle", 1'b0, osc_enable_out)
      port2_in <= port2_in | (8'h01 << ($urandom % 4 + 4 * i));
      wait_restart(12, 40);
    end
    watchdog_timeout_in <= 1'b1;
    @(posedge clk_in);
    watchdog_timeout_in <= 1'b0;
    wait_restart(12, 40);
    bus(1'b0, 6'h2C, 8'h00);
    `CHK("warm kept", 8'h80, q)
    power_ok_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    power_ok_in <= 1'b1;
    wait_restart(12, 40);
    bus(1'b0, 6'h2C, 8'h00);
    `CHK("cold", 8'h00, q)
    complete_run();
  end
endmodule
bind pmcc_top pmcc_properties pmcc_properties_inst (.clk_in, .resetn_in, .avs_read_in, .avs_write_in,
  .avs_waitrequest_out, .power_ok_in, .opcode_valid_in, .opcode_in, .cpu_clk_en_out, .cpu_run_out,
  .restart_out, .restart_addr_out, .osc_enable_out);
